// ---- hw/edge_event_controller.sv ----
/*
 * Edge and event line controller: nineteen lines, trigger select, masks,
 * pending bits and request outputs toward the interrupt controller.
 * Assumes all control inputs come from logic on ref_clk_i; line sources
 * are asynchronous and pass through edge_catch.
 * A new pin selection blanks its line for a few cycles while it syncs;
 * a real edge inside that gap is lost.
 * Two like edges inside one clock period can cancel, and neither is seen.
 */
//
// Behaviour
// - Nineteen independent lines, each able to raise an interrupt or an event.
// - Per line, rising, falling or both edges selectable independently.
// - Per-line masks; a masked line raises no request, others unaffected.
// - A readable pending bit per line records each interrupt request.
// - Edges shorter than one clock period are still caught.
// - Sixteen lines take general pins; any of eighty pins selectable per line.
// - Supply detector can request on fall below, rise above, or both.
// - Supply detector inactive and silent until software enables it.
// - Other sources are supply output, alarm, USB wakeup; any unmasked line wakes stop.
`timescale 1ns/1ps
`default_nettype none
module edge_event_controller
    import edge_event_pkg::*;
#(
    parameter int LINES = LINE_COUNT,
    parameter int PINS  = PIN_COUNT
) (
    // Clock and reset
    input  wire logic                                      ref_clk_i,
    input  wire logic                                      reset_n_i,
    // Sources
    input  wire logic [PINS-1:0]                           pin_i,
    input  wire logic                                      supply_level_detector_output_i,
    input  wire logic                                      alarm_i,
    input  wire logic                                      usb_wakeup_i,
    // Configuration
    input  wire logic [edge_event_pkg::PIN_LINES-1:0][edge_event_pkg::PIN_SEL_W-1:0] pin_sel_i,
    input  wire edge_event_pkg::trig_s [LINES-1:0]        trig_i,
    input  wire logic [LINES-1:0]                          irq_mask_i,
    input  wire logic [LINES-1:0]                          evt_mask_i,
    input  wire logic                                      supply_detector_en_i,
    // Pending clear
    input  wire logic [LINES-1:0]                          pend_clr_i,
    // Status and requests
    output logic [LINES-1:0]                               pending_o,
    output edge_event_pkg::req_s                           req_o,
    output logic                                           wake_o
);
    import edge_event_pkg::*;

    // ------------------------------------------------------------
    // Source routing
    // ------------------------------------------------------------
    logic [LINES-1:0] src;
    logic [LINES-1:0] hit;

    always_comb begin
        src = '0;
        for (int i = 0; i < PIN_LINES; i++) begin
            src[i] = (int'(pin_sel_i[i]) < PINS) ? pin_i[pin_sel_i[i]] : 1'b0;
        end
        src[LINE_SUPPLY] = supply_level_detector_output_i & supply_detector_en_i;
        src[LINE_ALARM]  = alarm_i;
        src[LINE_USB]    = usb_wakeup_i;
    end

    // ------------------------------------------------------------
    // Edge catchers, one per line
    // ------------------------------------------------------------
    for (genvar g = 0; g < LINES; g++) begin : g_line
        edge_catch u_catch (
            .ref_clk_i (ref_clk_i),
            .reset_n_i (reset_n_i),
            .line_i    (src[g]),
            .rise_en_i (trig_i[g].rise),
            .fall_en_i (trig_i[g].fall),
            .ack_i     (1'b0),
            .flag_o    (hit[g])
        );
    end

    // ------------------------------------------------------------
    // Pin selection settle
    // ------------------------------------------------------------
    // A new pin may look like an edge; blank the line until it has synced
    logic       [PIN_LINES-1:0][PIN_SEL_W-1:0] sel_q;
    logic       [PIN_LINES-1:0][PIN_SEL_W-1:0] sel_d;
    src_state_e                                slot_q [PIN_LINES];
    src_state_e                                slot_d [PIN_LINES];
    logic       [PIN_LINES-1:0][SETTLE_W-1:0]  settle_q;
    logic       [PIN_LINES-1:0][SETTLE_W-1:0]  settle_d;
    logic       [PIN_LINES-1:0]                moved;
    logic       [LINES-1:0]                    blank;

    always_comb begin
        sel_d    = pin_sel_i;
        settle_d = settle_q;
        blank    = '0;
        for (int i = 0; i < PIN_LINES; i++) begin
            slot_d[i] = slot_q[i];
            moved[i]  = (pin_sel_i[i] != sel_q[i]);
            case (slot_q[i])
                SRC_RUN: begin
                    if (moved[i]) begin
                        slot_d[i]   = SRC_IDLE;
                        settle_d[i] = SEL_SETTLE;
                    end
                end
                SRC_IDLE: begin
                    if (moved[i]) begin
                        settle_d[i] = SEL_SETTLE;
                    end else if (settle_q[i] == '0) begin
                        slot_d[i] = SRC_RUN;
                    end else begin
                        settle_d[i] = settle_q[i] - 1'b1;
                    end
                end
                default: begin
                    slot_d[i]   = SRC_IDLE;
                    settle_d[i] = SEL_SETTLE;
                end
            endcase
            blank[i] = (slot_q[i] == SRC_IDLE);
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            // Lines whose selection is not zero settle once after reset
            sel_q    <= '0;
            settle_q <= '0;
            for (int i = 0; i < PIN_LINES; i++) begin
                slot_q[i] <= SRC_RUN;
            end
        end else begin
            sel_q    <= sel_d;
            settle_q <= settle_d;
            for (int i = 0; i < PIN_LINES; i++) begin
                slot_q[i] <= slot_d[i];
            end
        end
    end

    // ------------------------------------------------------------
    // Qualified hits
    // ------------------------------------------------------------
    logic [LINES-1:0] live;
    logic [LINES-1:0] sup_gate;

    always_comb begin
        // Line 16 stays silent while the detector is off
        live                  = hit & ~blank;
        sup_gate              = '1;
        sup_gate[LINE_SUPPLY] = supply_detector_en_i;
    end

    // ------------------------------------------------------------
    // Pending bits
    // ------------------------------------------------------------
    logic [LINES-1:0] pending_q;
    logic [LINES-1:0] pending_d;

    always_comb begin
        // Set wins over clear in the same cycle
        pending_d = (pending_q & ~pend_clr_i) | (live & irq_mask_i & sup_gate);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pending_q <= LINES_RESET;
        end else begin
            pending_q <= pending_d;
        end
    end

    // ------------------------------------------------------------
    // Requests toward the interrupt controller
    // ------------------------------------------------------------
    req_s req_q;
    req_s req_d;

    always_comb begin
        // Interrupt is a level, event a one-cycle pulse
        req_d.irq = pending_d & irq_mask_i;
        req_d.evt = live & evt_mask_i & sup_gate;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            req_q <= '0;
        end else begin
            req_q <= req_d;
        end
    end

    // ------------------------------------------------------------
    // Stop-state wake
    // ------------------------------------------------------------
    logic wake_q;
    logic wake_d;

    always_comb begin
        // Any unmasked line may end the stop state
        wake_d = |(live & (irq_mask_i | evt_mask_i) & sup_gate);
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wake_q <= 1'b0;
        end else begin
            wake_q <= wake_d;
        end
    end

    assign pending_o = pending_q;
    assign req_o     = req_q;
    assign wake_o    = wake_q;
endmodule
`default_nettype wire

// ---- include/edge_event_pkg.sv ----
/*
 * Shared constants and carriers for the edge and event line controller.
 * Assumes a single 20 MHz clock domain and plain control ports.
 */
`default_nettype none
package edge_event_pkg;
    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int LINE_COUNT   = 19;
    localparam int PIN_LINES    = 16;
    localparam int PIN_COUNT    = 80;
    localparam int PIN_SEL_W    = 7;
    localparam int LINE_SUPPLY  = 16;
    localparam int LINE_ALARM   = 17;
    localparam int LINE_USB     = 18;
    localparam logic [LINE_COUNT-1:0] LINES_RESET = 19'h0_0000;
    // Blank counter reload; a line stays blank one cycle longer than this after its pin selection changes
    localparam int                    SETTLE_W    = 3;
    localparam logic [SETTLE_W-1:0]   SEL_SETTLE  = 3'h5;

    // ------------------------------------------------------------
    // Trigger selection per line
    // ------------------------------------------------------------
    typedef struct packed {
        logic rise;
        logic fall;
    } trig_s;

    typedef struct packed {
        logic [LINE_COUNT-1:0] irq;
        logic [LINE_COUNT-1:0] evt;
    } req_s;

    // Pin selection slot state
    typedef enum logic [1:0] {
        SRC_IDLE = 2'b00,
        SRC_RUN  = 2'b01
    } src_state_e;
endpackage
`default_nettype wire

// ---- hw/edge_catch.sv ----
/*
 * One edge catcher: latches an edge of any width on its own input as clock.
 * Flag is a one-cycle pulse already on ref_clk_i; ack_i is synchronised but unused.
 */
`timescale 1ns/1ps
`default_nettype none
module edge_catch (
    // Clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_n_i,
    // Line and trigger
    input  wire logic line_i,
    input  wire logic rise_en_i,
    input  wire logic fall_en_i,
    // Toggle handshake
    input  wire logic ack_i,
    output logic      flag_o
);
    // ------------------------------------------------------------
    // Asynchronous capture
    // ------------------------------------------------------------
    logic rise_tog_q;
    logic fall_tog_q;
    logic rise_tog_d;
    logic fall_tog_d;
    logic ack_s1_q;
    logic ack_s2_q;
    logic seen_q;
    logic seen_d;

    // Toggles run on the line itself, so pulses below a clock period still land
    always_comb begin
        rise_tog_d = ~rise_tog_q;
        fall_tog_d = ~fall_tog_q;
    end

    always_ff @(posedge line_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_tog_q <= 1'b0;
        end else begin
            rise_tog_q <= rise_tog_d;
        end
    end

    always_ff @(negedge line_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            fall_tog_q <= 1'b0;
        end else begin
            fall_tog_q <= fall_tog_d;
        end
    end

    // ------------------------------------------------------------
    // Clock-side synchronise and compare
    // ------------------------------------------------------------
    logic rise_s1_q;
    logic rise_s2_q;
    logic rise_s3_q;
    logic fall_s1_q;
    logic fall_s2_q;
    logic fall_s3_q;
    logic hit;

    always_comb begin
        hit    = (rise_en_i & (rise_s2_q ^ rise_s3_q)) | (fall_en_i & (fall_s2_q ^ fall_s3_q));
        seen_d = hit;
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rise_s1_q <= 1'b0;
            rise_s2_q <= 1'b0;
            rise_s3_q <= 1'b0;
            fall_s1_q <= 1'b0;
            fall_s2_q <= 1'b0;
            fall_s3_q <= 1'b0;
            ack_s1_q  <= 1'b0;
            ack_s2_q  <= 1'b0;
            seen_q    <= 1'b0;
        end else begin
            rise_s1_q <= rise_tog_q;
            rise_s2_q <= rise_s1_q;
            rise_s3_q <= rise_s2_q;
            fall_s1_q <= fall_tog_q;
            fall_s2_q <= fall_s1_q;
            fall_s3_q <= fall_s2_q;
            ack_s1_q  <= ack_i;
            ack_s2_q  <= ack_s1_q;
            seen_q    <= seen_d;
        end
    end

    assign flag_o = seen_q;
endmodule
`default_nettype wire

// ---- test/edge_src_model.sv ----
/* Source model: general pins, supply output, alarm and USB wakeup.
   Toggles or glitches a source on request from the bench clock. */
`timescale 1ns/1ps
`default_nettype none
module edge_src_model (
    // Clock and requests
    input  wire logic        ref_clk_i,
    input  wire logic [82:0] tog_i,
    input  wire logic [82:0] pls_i,
    // Sources
    output var  logic [82:0] src_o
);
    logic [82:0] lvl_q = '0;
    logic [82:0] pls_q = '0;
    initial src_o = '0;
    // Changes land 5 ns after the edge; glitch lasts 10 ns
    always @(posedge ref_clk_i) begin
        lvl_q = lvl_q ^ tog_i;
        pls_q = pls_i;
        #5;
        src_o = lvl_q ^ pls_q;
        #10;
        src_o = lvl_q;
    end
endmodule
`default_nettype wire

// ---- test/edge_event_controller_monitor.sv ----
/* Port checker for the edge event controller.
   Bound to the controller; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module edge_event_controller_monitor
    import edge_event_pkg::*;
#(
    parameter int LINES = LINE_COUNT
) (
    // Clock and reset
    input wire logic                 ref_clk_i,
    input wire logic                 reset_n_i,
    // Watched ports
    input wire logic                 supply_detector_en_i,
    input wire logic [LINES-1:0]     irq_mask_i,
    input wire logic [LINES-1:0]     evt_mask_i,
    input wire logic [LINES-1:0]     pend_clr_i,
    input wire logic [LINES-1:0]     pending_o,
    input wire edge_event_pkg::req_s req_o,
    input wire logic                 wake_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);
    property p_reset; $rose(reset_n_i) |-> pending_o == '0 && req_o == '0 && !wake_o; endproperty
    a_reset: assert property (p_reset) else $error("outputs set after reset");
    property p_irq; (req_o.irq & ~pending_o) == '0; endproperty
    a_irq: assert property (p_irq) else $error("irq without pending");
    property p_hold; ($past(pending_o) & ~$past(pend_clr_i) & ~pending_o) == '0; endproperty
    a_hold: assert property (p_hold) else $error("pending lost");
    property p_mask; (pending_o & ~$past(pending_o) & ~$past(irq_mask_i)) == '0; endproperty
    a_mask: assert property (p_mask) else $error("masked pending");
    property p_evt_mask; (req_o.evt & ~$past(evt_mask_i)) == '0; endproperty
    a_evt_mask: assert property (p_evt_mask) else $error("masked event");
    property p_evt_wake; |req_o.evt |-> wake_o; endproperty
    a_evt_wake: assert property (p_evt_wake) else $error("event without wake");
    property p_supply;
        !supply_detector_en_i && !$past(supply_detector_en_i) |->
            !req_o.evt[LINE_SUPPLY] && !$rose(pending_o[LINE_SUPPLY]);
    endproperty
    a_supply: assert property (p_supply) else $error("supply line active");
    property p_wake; wake_o |-> |(req_o.irq | req_o.evt); endproperty
    a_wake: assert property (p_wake) else $error("wake without request");
    c_pend: cover property (|pending_o);
    c_evt: cover property (|req_o.evt);
    c_wake: cover property (wake_o);
    c_supply: cover property (req_o.evt[LINE_SUPPLY]);
endmodule
bind edge_event_controller edge_event_controller_monitor #(.LINES(LINES)) u_edge_event_controller_monitor (
    .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .supply_detector_en_i(supply_detector_en_i),
    .irq_mask_i(irq_mask_i), .evt_mask_i(evt_mask_i), .pend_clr_i(pend_clr_i),
    .pending_o(pending_o), .req_o(req_o), .wake_o(wake_o));
`default_nettype wire

// ---- test/edge_event_controller_tb_top.sv ----
/* Bench for the edge event controller.
   Sources come from edge_src_model; controls driven here. */
`timescale 1ns/1ps
`default_nettype none
module edge_event_controller_tb_top;
    import edge_event_pkg::*;
    logic             ref_clk_i = 1'b0;
    logic             reset_n_i = 1'b0;
    logic             sde       = 1'b0;
    logic [82:0]      tog       = '0;
    logic [82:0]      pls       = '0;
    logic [82:0]      src;
    logic [15:0][6:0] sel       = {7'h4F, {13{7'h7F}}, 7'h00, 7'h00};
    trig_s [18:0]     trig      = '0;
    logic [18:0]      irq_m     = '1;
    logic [18:0]      evt_m     = '1;
    logic [18:0]      clr       = '0;
    logic [18:0]      pend;
    logic [18:0]      seen      = '0;
    logic [18:0]      irq_v;
    logic             woke      = 1'b0;
    req_s             req;
    logic             wake;
    int               n_errors  = 0;
    int               checks    = 0;
    int               cyc       = 0;
    int               sa[9]     = '{0, 0, 0, 0, 0, 0, 79, 81, 82};
    int               la[9]     = '{0, 0, 0, 0, 0, 0, 15, 17, 18};
    int               ta[9]     = '{2, 2, 1, 1, 3, 0, 2, 2, 3};
    int               ea[9]     = '{1, 0, 0, 1, 1, 0, 1, 1, 1};
    edge_src_model u_edge_src_model (.ref_clk_i(ref_clk_i), .tog_i(tog), .pls_i(pls), .src_o(src));
    edge_event_controller u_edge_event_controller (
        .ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .pin_i(src[79:0]),
        .supply_level_detector_output_i(src[80]), .alarm_i(src[81]), .usb_wakeup_i(src[82]),
        .pin_sel_i(sel), .trig_i(trig), .irq_mask_i(irq_m), .evt_mask_i(evt_m),
        .supply_detector_en_i(sde), .pend_clr_i(clr), .pending_o(pend), .req_o(req), .wake_o(wake));
    always #25 ref_clk_i = ~ref_clk_i;
    always_comb irq_v = req.irq;
    always @(posedge ref_clk_i) begin
        seen <= (&clr) ? '0 : seen | req.evt;
        woke <= (&clr) ? 1'b0 : woke | wake;
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            n_errors++;
            summarize();
        end
    end
    task automatic chk(input string nm, input logic [18:0] e, ref logic [18:0] g);
        @(negedge ref_clk_i);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, ref logic g);
        @(negedge ref_clk_i);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("Error %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic fire(input int s, input bit p, input logic [37:0] t);
        @(posedge ref_clk_i);
        trig <= t;
        if (p)
            pls <= 83'(1) << s;
        else
            tog <= 83'(1) << s;
        @(posedge ref_clk_i);
        pls <= '0;
        tog <= '0;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task automatic wipe;
        @(posedge ref_clk_i);
        clr <= '1;
        @(posedge ref_clk_i);
        clr <= '0;
        @(posedge ref_clk_i);
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge ref_clk_i);
        reset_n_i <= 1'b1;
        chk("pending", 19'h0_0000, pend);
        foreach (sa[i]) begin
            fire(sa[i], 1'b0, 38'(ta[i]) << (2 * la[i]));
            chk("pending", 19'(ea[i]) << la[i], pend);
            chk("event", 19'(ea[i]) << la[i], seen);
            chk("irq", 19'(ea[i]) << la[i], irq_v);
            chk_bit("wake", ea[i][0], woke);
            wipe();
            chk("cleared", 19'h0_0000, pend);
        end
        @(posedge ref_clk_i);
        irq_m <= 19'h7_FFFE;
        evt_m <= 19'h7_FFFE;
        fire(0, 1'b0, 38'h00_0000_000F);
        chk("pending", 19'h0_0002, pend);
        chk("event", 19'h0_0002, seen);
        chk("irq", 19'h0_0002, irq_v);
        chk_bit("wake", 1'b1, woke);
        wipe();
        irq_m <= '1;
        evt_m <= '1;
        fire(0, 1'b1, 38'h00_0000_0002);
        chk("pending", 19'h0_0001, pend);
        chk_bit("wake", 1'b1, woke);
        wipe();
        for (int k = 0; k < 4; k++) begin
            @(posedge ref_clk_i);
            sde <= (k > 1);
            fire(80, 1'b0, 38'h03_0000_0000);
            chk("supply", (k > 1) ? 19'h1_0000 : 19'h0_0000, pend);
            chk_bit("wake", k > 1, woke);
            wipe();
        end
        fire(0, 1'b0, 38'h00_0000_0003);
        reset_n_i <= 1'b0;
        chk("reset", 19'h0_0000, pend);
        summarize();
    end
endmodule
`default_nettype wire
